// File: shared/imfl_defs.svh
// register offsets, field positions and reset values of the mask and line-control slice
`ifndef IMFL_DEFS_SVH
`define IMFL_DEFS_SVH

`define IMFL_OFS_DATA_A       8'h00
`define IMFL_OFS_DATA_B       8'h01
`define IMFL_OFS_IRQ_MASK     8'h03
`define IMFL_OFS_FILL_A       8'h04
`define IMFL_OFS_FILL_B       8'h05
`define IMFL_OFS_LINE_CTRL_A  8'h06

`define IMFL_RST_IRQ_MASK     8'h00
`define IMFL_RST_FILL_A       8'h01
`define IMFL_RST_FILL_B       8'h00
`define IMFL_RST_LINE_CTRL_A  8'h00

`define IMFL_BIT_FAULT_EVT    7
`define IMFL_BIT_WAKE_EVT     6
`define IMFL_BIT_TX_FAULT_B   5
`define IMFL_BIT_TX_FAULT_A   4
`define IMFL_BIT_RX_FAULT_B   3
`define IMFL_BIT_RX_FAULT_A   2
`define IMFL_BIT_RX_READY_B   1
`define IMFL_BIT_RX_READY_A   0

`define IMFL_LC_RATE_HI       7
`define IMFL_LC_RATE_LO       6
`define IMFL_LC_SETUP_START   5
`define IMFL_LC_WAKE_PULSE    4
`define IMFL_LC_TX_CLEAR      3
`define IMFL_LC_RX_CLEAR      2
`define IMFL_LC_CYCLE_TIMER   1
`define IMFL_LC_SEND          0

`endif

// File: shared/imfl_pkg.sv
// types shared by the mask and line-control slice
package imfl_pkg;

	typedef enum logic [1:0] {
		IMFL_RATE_FAIL = 2'b00,
		IMFL_RATE_4K8  = 2'b01,
		IMFL_RATE_38K4 = 2'b10,
		IMFL_RATE_230K = 2'b11
	} imfl_rate_t;

	typedef enum logic [0:0] {
		IMFL_HDR_NONE    = 1'b0,
		IMFL_HDR_PENDING = 1'b1
	} imfl_hdr_t;

endpackage : imfl_pkg

// File: rtl/imfl_fill_counter.sv
// receive queue level counter that leaves out the inserted length byte
`timescale 1ns/1ps
module imfl_fill_counter #(
	parameter logic [7:0] RESET_LEVEL = 8'h00
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       push_data,
	input  wire logic       push_hdr,
	input  wire logic       pop,
	input  wire logic       clear,
	output logic [7:0]      level
);

	logic [7:0]       level_r;
	logic [7:0]       level_nxt;
	imfl_pkg::imfl_hdr_t hdr_r;
	imfl_pkg::imfl_hdr_t hdr_nxt;

	always_comb begin
		level_nxt = level_r;
		hdr_nxt   = hdr_r;
		if (clear) begin
			level_nxt = 8'h00;
			hdr_nxt   = imfl_pkg::IMFL_HDR_NONE;
		end else begin
			// the length byte is queued but never counted; its read-out is absorbed
			if (push_hdr) begin
				hdr_nxt = imfl_pkg::IMFL_HDR_PENDING;
			end
			if (pop && hdr_r == imfl_pkg::IMFL_HDR_PENDING) begin
				hdr_nxt = push_hdr ? imfl_pkg::IMFL_HDR_PENDING : imfl_pkg::IMFL_HDR_NONE;
				if (push_data && level_r != 8'hFF) begin
					level_nxt = level_r + 8'h01;
				end
			end else if (push_data && !pop) begin
				if (level_r != 8'hFF) begin
					level_nxt = level_r + 8'h01;
				end
			end else if (pop && !push_data) begin
				if (level_r != 8'h00) begin
					level_nxt = level_r - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			level_r <= RESET_LEVEL;
			hdr_r   <= imfl_pkg::IMFL_HDR_NONE;
		end else begin
			level_r <= level_nxt;
			hdr_r   <= hdr_nxt;
		end
	end

	// the count moves on data pushes, data pops and clear only; the length byte's push and its pop leave it alone
	assign level = level_r;

endmodule : imfl_fill_counter

// File: rtl/imfl_top.sv
// interrupt mask, receive levels and channel A line control registers
//
// Operation
// - status/supply fault event reaches irq only while mask bit 7 is set
// - wake sequence completion reaches irq only while mask bit 6 is set
// - transmitter faults B and A gated by mask bits 5 and 4
// - receiver faults B and A gated by mask bits 3 and 2
// - receive fault enables leave the receive fault pins untouched
// - data ready B and A gated by mask bits 1 and 0
// - data ready enables leave the receive ready pins untouched
// - read-only level shows message bytes in each receive queue; channel A's level starts at 1 out of reset
// - inserted length byte at message head is not counted
// - level may be off by one while receiving; host trusts it only idle
// - line control A holds rate, start, wake, clears, timer, send; reset zero
// - successful link setup writes detected rate into the rate field
// - rate codes: 00 failure, 01 4.8k, 10 38.4k, 11 230.4k
// - reading a channel data register clears that channel's data ready flag
// - failed setup raises wake event, drops start bit, leaves rate zero
// - send trigger transmits queued message then turns line to receive
// - queue clear bits empty transmit and receive queues
`timescale 1ns/1ps
`include "imfl_defs.svh"
module imfl_top (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	input  wire logic [7:0] event_flags,
	output logic            irq,
	input  wire logic       rx_push_data_a,
	input  wire logic       rx_push_hdr_a,
	input  wire logic       rx_push_data_b,
	input  wire logic       rx_push_hdr_b,
	output logic            rx_ready_clear_a,
	output logic            rx_ready_clear_b,
	input  wire logic       setup_done_a,
	input  wire logic       setup_ok_a,
	input  wire logic [1:0] setup_rate_a,
	output logic            wake_event_set,
	input  wire logic       wake_done_a,
	input  wire logic       send_done_a,
	output logic            line_tx_mode_a,
	output logic [7:0]      line_ctrl_a,
	output logic            tx_queue_clear_a,
	output logic            rx_queue_clear_a
);

	logic [7:0] irq_mask_ctrl_r;
	logic [7:0] irq_mask_ctrl_nxt;
	logic [7:0] line_ctrl_a_r;
	logic [7:0] line_ctrl_a_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       irq_r;
	logic       irq_nxt;
	logic       rdy_clr_a_r;
	logic       rdy_clr_a_nxt;
	logic       rdy_clr_b_r;
	logic       rdy_clr_b_nxt;
	logic       wake_set_r;
	logic       wake_set_nxt;
	logic       tx_mode_r;
	logic       tx_mode_nxt;
	logic       tx_clr_r;
	logic       tx_clr_nxt;
	logic       rx_clr_r;
	logic       rx_clr_nxt;
	logic [7:0] rx_fill_a;
	logic [7:0] rx_fill_b;
	logic       pop_a;
	logic       pop_b;
	logic       lc_wr;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	assign pop_a = reg_rd && hit(reg_addr, `IMFL_OFS_DATA_A);
	assign pop_b = reg_rd && hit(reg_addr, `IMFL_OFS_DATA_B);
	assign lc_wr = reg_wr && hit(reg_addr, `IMFL_OFS_LINE_CTRL_A);

	imfl_fill_counter #(.RESET_LEVEL(`IMFL_RST_FILL_A)) u_fill_a (
		.core_clk  (core_clk),
		.rst       (rst),
		.push_data (rx_push_data_a),
		.push_hdr  (rx_push_hdr_a),
		.pop       (pop_a),
		.clear     (rx_clr_r),
		.level     (rx_fill_a)
	);

	imfl_fill_counter #(.RESET_LEVEL(`IMFL_RST_FILL_B)) u_fill_b (
		.core_clk  (core_clk),
		.rst       (rst),
		.push_data (rx_push_data_b),
		.push_hdr  (rx_push_hdr_b),
		.pop       (pop_b),
		.clear     (1'b0),
		.level     (rx_fill_b)
	);

	// register writes and hardware updates of line control
	always_comb begin
		irq_mask_ctrl_nxt = irq_mask_ctrl_r;
		line_ctrl_a_nxt   = line_ctrl_a_r;
		tx_clr_nxt        = 1'b0;
		rx_clr_nxt        = 1'b0;
		wake_set_nxt      = 1'b0;
		tx_mode_nxt       = tx_mode_r;
		if (reg_wr) begin
			if (hit(reg_addr, `IMFL_OFS_IRQ_MASK)) begin
				irq_mask_ctrl_nxt = reg_wdata;
			end else if (hit(reg_addr, `IMFL_OFS_LINE_CTRL_A)) begin
				line_ctrl_a_nxt = reg_wdata;
			end
		end
		// clear bits act for one cycle and fall back; a same-cycle host write of 1 wins
		if (line_ctrl_a_r[`IMFL_LC_TX_CLEAR]) begin
			tx_clr_nxt = 1'b1;
			line_ctrl_a_nxt[`IMFL_LC_TX_CLEAR] = lc_wr && reg_wdata[`IMFL_LC_TX_CLEAR];
		end
		if (line_ctrl_a_r[`IMFL_LC_RX_CLEAR]) begin
			rx_clr_nxt = 1'b1;
			line_ctrl_a_nxt[`IMFL_LC_RX_CLEAR] = lc_wr && reg_wdata[`IMFL_LC_RX_CLEAR];
		end
		if (line_ctrl_a_r[`IMFL_LC_SEND] && !send_done_a) begin
			tx_mode_nxt = 1'b1;
		end
		if (send_done_a) begin
			tx_mode_nxt = 1'b0;
			line_ctrl_a_nxt[`IMFL_LC_SEND] = lc_wr && reg_wdata[`IMFL_LC_SEND];
		end
		if (wake_done_a) begin
			line_ctrl_a_nxt[`IMFL_LC_WAKE_PULSE] = lc_wr && reg_wdata[`IMFL_LC_WAKE_PULSE];
		end
		// hardware result beats a same-cycle host write of the field
		if (setup_done_a) begin
			wake_set_nxt = 1'b1;
			line_ctrl_a_nxt[`IMFL_LC_SETUP_START] = 1'b0;
			if (setup_ok_a) begin
				line_ctrl_a_nxt[`IMFL_LC_RATE_HI:`IMFL_LC_RATE_LO] = setup_rate_a;
			end else begin
				line_ctrl_a_nxt[`IMFL_LC_RATE_HI:`IMFL_LC_RATE_LO] =
					imfl_pkg::IMFL_RATE_FAIL;
			end
		end
	end

	// readback; reads have no side effect on these registers
	always_comb begin
		rdata_nxt     = rdata_r;
		rdy_clr_a_nxt = pop_a;
		rdy_clr_b_nxt = pop_b;
		if (reg_rd) begin
			if (hit(reg_addr, `IMFL_OFS_IRQ_MASK)) begin
				rdata_nxt = irq_mask_ctrl_r;
			end else if (hit(reg_addr, `IMFL_OFS_FILL_A)) begin
				rdata_nxt = rx_fill_a;
			end else if (hit(reg_addr, `IMFL_OFS_FILL_B)) begin
				rdata_nxt = rx_fill_b;
			end else if (hit(reg_addr, `IMFL_OFS_LINE_CTRL_A)) begin
				rdata_nxt = line_ctrl_a_r;
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	// pins for receive fault and ready are driven from the raw flags elsewhere, not from here
	always_comb begin
		irq_nxt = |(event_flags & irq_mask_ctrl_r);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_mask_ctrl_r <= `IMFL_RST_IRQ_MASK;
			line_ctrl_a_r   <= `IMFL_RST_LINE_CTRL_A;
			rdata_r         <= 8'h00;
			irq_r           <= 1'b0;
			rdy_clr_a_r     <= 1'b0;
			rdy_clr_b_r     <= 1'b0;
			wake_set_r      <= 1'b0;
			tx_mode_r       <= 1'b0;
			tx_clr_r        <= 1'b0;
			rx_clr_r        <= 1'b0;
		end else begin
			irq_mask_ctrl_r <= irq_mask_ctrl_nxt;
			line_ctrl_a_r   <= line_ctrl_a_nxt;
			rdata_r         <= rdata_nxt;
			irq_r           <= irq_nxt;
			rdy_clr_a_r     <= rdy_clr_a_nxt;
			rdy_clr_b_r     <= rdy_clr_b_nxt;
			wake_set_r      <= wake_set_nxt;
			tx_mode_r       <= tx_mode_nxt;
			tx_clr_r        <= tx_clr_nxt;
			rx_clr_r        <= rx_clr_nxt;
		end
	end

	assign reg_rdata        = rdata_r;
	assign irq              = irq_r;
	assign rx_ready_clear_a = rdy_clr_a_r;
	assign rx_ready_clear_b = rdy_clr_b_r;
	assign wake_event_set   = wake_set_r;
	assign line_tx_mode_a   = tx_mode_r;
	assign line_ctrl_a      = line_ctrl_a_r;
	assign tx_queue_clear_a = tx_clr_r;
	assign rx_queue_clear_a = rx_clr_r;

endmodule : imfl_top

// File: testbench/imfl_top_properties.sv
// concurrent checks on the ports of the mask and line-control slice
`timescale 1ns/1ps
module imfl_top_chk (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] event_flags,
	input wire logic       irq,
	input wire logic       rx_ready_clear_a,
	input wire logic       rx_ready_clear_b,
	input wire logic       setup_done_a,
	input wire logic       wake_event_set,
	input wire logic       send_done_a,
	input wire logic       line_tx_mode_a,
	input wire logic       tx_queue_clear_a,
	input wire logic       rx_queue_clear_a
);
	// shadow of the mask, rebuilt from host writes only
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	always_comb mask_nxt = (reg_wr && reg_addr == 8'h03) ? reg_wdata : mask_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) mask_r <= 8'h00;
		else mask_r <= mask_nxt;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_FAULT_EN: assert property (event_flags[7] && mask_r[7] |=> irq)
		else $error("irq missing for fault event");
	AST_WAKE_EN: assert property (event_flags[6] && mask_r[6] |=> irq)
		else $error("irq missing for wake event");
	AST_TX_EN: assert property (|(event_flags[5:4] & mask_r[5:4]) |=> irq)
		else $error("irq missing for transmit fault");
	AST_RX_EN: assert property (|(event_flags[3:0] & mask_r[3:0]) |=> irq)
		else $error("irq missing for receive event");
	AST_IRQ_LOW: assert property (!(|(event_flags & mask_r)) |=> !irq)
		else $error("irq high with no enabled flag");
	AST_MASK_RD: assert property (reg_rd && !reg_wr && reg_addr == 8'h03
		|=> reg_rdata == mask_r)
		else $error("mask readback differs");
	AST_QCLR: assert property (reg_wr && reg_addr == 8'h06 |-> ##2
		{tx_queue_clear_a, rx_queue_clear_a} == $past(reg_wdata[3:2], 2))
		else $error("queue clear pulse wrong");
	AST_RDY_CLR: assert property (reg_rd && reg_addr == 8'h00 |=> rx_ready_clear_a)
		else $error("data ready not cleared on data read");
	AST_RDY_CLR_B: assert property (reg_rd && reg_addr == 8'h01 |=> rx_ready_clear_b)
		else $error("data ready B not cleared on data read");
	AST_WAKE_SET: assert property (setup_done_a |=> wake_event_set)
		else $error("wake event missing after setup");
	AST_SEND_END: assert property ($fell(line_tx_mode_a) |-> $past(send_done_a))
		else $error("line left transmit early");
endmodule : imfl_top_chk
bind imfl_top imfl_top_chk u_chk (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .event_flags, .irq, .rx_ready_clear_a, .rx_ready_clear_b, .setup_done_a,
	.wake_event_set,
	.send_done_a, .line_tx_mode_a, .tx_queue_clear_a, .rx_queue_clear_a);

// File: testbench/imfl_link_model.sv
// far-side model: receivers, link setup sequencer and transmit completion
`timescale 1ns/1ps
module imfl_link_model (
	input  wire logic core_clk,
	output logic       pd_a,
	output logic       ph_a,
	output logic       pd_b,
	output logic       ph_b,
	output logic       sd,
	output logic       sok,
	output logic [1:0] srate,
	output logic       wd,
	output logic       snd
);
	initial {pd_a, ph_a, pd_b, ph_b, sd, sok, srate, wd, snd} = 10'h000;
	task automatic msg_a(input int n);
		@(posedge core_clk) #1 ph_a = 1'b1;
		repeat (n) @(posedge core_clk) #1 {ph_a, pd_a} = 2'b01;
		@(posedge core_clk) #1 pd_a = 1'b0;
	endtask : msg_a
	task automatic data_b(input int n);
		@(posedge core_clk) #1 ph_b = 1'b1;
		repeat (n) @(posedge core_clk) #1 {ph_b, pd_b} = 2'b01;
		@(posedge core_clk) #1 pd_b = 1'b0;
	endtask : data_b
	// result lines are inverted once the done pulse is over
	task automatic setup(input logic ok, input logic [1:0] r, input int dly);
		repeat (dly) @(posedge core_clk);
		@(posedge core_clk) #1 {sd, sok, srate} = {1'b1, ok, r};
		@(posedge core_clk) #1 {sd, sok, srate} = {1'b0, ~ok, ~r};
	endtask : setup
	task automatic done(input logic send);
		@(posedge core_clk) #1 {snd, wd} = {send, ~send};
		@(posedge core_clk) #1 {snd, wd} = 2'b00;
	endtask : done
endmodule : imfl_link_model

// File: testbench/tb_top.sv
// self-checking bench for the mask, level and line-control registers
`timescale 1ns/1ps
`include "imfl_defs.svh"
module tb_top;
	logic       core_clk, rst, reg_wr, reg_rd, irq, line_tx_mode_a;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, event_flags, line_ctrl_a;
	wire logic  pd_a, ph_a, pd_b, ph_b, sd, sok, wd, snd;
	wire logic [1:0] srate;
	int         fails, compares;
	imfl_top dut (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.event_flags, .irq, .rx_push_data_a(pd_a), .rx_push_hdr_a(ph_a), .rx_push_data_b(pd_b),
		.rx_push_hdr_b(ph_b), .rx_ready_clear_a(), .rx_ready_clear_b(), .setup_done_a(sd),
		.setup_ok_a(sok), .setup_rate_a(srate), .wake_event_set(), .wake_done_a(wd),
		.send_done_a(snd), .line_tx_mode_a, .line_ctrl_a, .tx_queue_clear_a(),
		.rx_queue_clear_a());
	imfl_link_model u_link (.core_clk, .pd_a, .ph_a, .pd_b, .ph_b, .sd, .sok, .srate, .wd,
		.snd);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge core_clk) #1 reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk) #1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge core_clk) #1 reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), exp, d);
	endtask : chkr
	task automatic t_reset;
		chkr(8'h03, 8'h00);
		chkr(8'h04, `IMFL_RST_FILL_A);
		chkr(8'h05, 8'h00);
		chkr(8'h06, 8'h00);
		chkr(8'h0F, 8'h00);
	endtask : t_reset
	task automatic t_mask;
		wr(8'h03, 8'hA5);
		chkr(8'h03, 8'hA5);
		chkr(8'h03, 8'hA5);
		for (int i = 0; i < 8; i++) begin
			event_flags = 8'h01 << i;
			wr(8'h03, ~event_flags);
			@(posedge core_clk) #1 chk("irq", 8'h00, {7'h00, irq});
			wr(8'h03, event_flags);
			@(posedge core_clk) #1 chk("irq", 8'h01, {7'h00, irq});
		end
		event_flags = 8'h00;
	endtask : t_mask
	task automatic t_fill;
		logic [7:0] d;
		u_link.msg_a(3);
		u_link.data_b(2);
		// levels are read only once both receivers are idle
		chkr(8'h04, `IMFL_RST_FILL_A + 8'h03);
		chkr(8'h05, 8'h02);
		rd(8'h00, d);
		rd(8'h00, d);
		chkr(8'h04, `IMFL_RST_FILL_A + 8'h02);
		rd(8'h01, d);
		rd(8'h01, d);
		chkr(8'h05, 8'h01);
		wr(8'h05, 8'hFF);
		chkr(8'h05, 8'h01);
		wr(8'h06, 8'h0C);
		// the clear pulse reaches the counter two edges after the write
		@(posedge core_clk);
		chkr(8'h04, 8'h00);
		chkr(8'h06, 8'h00);
	endtask : t_fill
	task automatic t_setup;
		for (int r = 0; r < 4; r++) begin
			wr(8'h06, 8'h20);
			// the failing case offers a nonzero rate that must not land
			u_link.setup(r != 0, (r == 0) ? 2'b11 : r[1:0], r * 3);
			chkr(8'h06, {r[1:0], 6'h00});
		end
	endtask : t_setup
	task automatic t_send;
		wr(8'h06, 8'h03);
		@(posedge core_clk) #1 chk("tx mode", 8'h01, {7'h00, line_tx_mode_a});
		u_link.done(1'b1);
		@(posedge core_clk) #1 chk("tx mode", 8'h00, {7'h00, line_tx_mode_a});
		chkr(8'h06, 8'h02);
		chk("line ctrl", 8'h02, line_ctrl_a);
		wr(8'h06, 8'h12);
		chkr(8'h06, 8'h12);
		u_link.done(1'b0);
		chkr(8'h06, 8'h02);
	endtask : t_send
	task automatic stop_test;
		if (fails == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, event_flags} = 26'h0000000;
		repeat (8) @(posedge core_clk);
		#1 rst = 1'b0;
		t_reset;
		t_mask;
		t_fill;
		t_setup;
		t_send;
		stop_test;
	end
	// the whole run needs well under two thousand cycles
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule : tb_top
